// ### src/ptc_defines.vh
// Constants for the paired timer control block: register map, field
// positions, reset values and prescale terminal counts.
// Assumes inclusion by bare name from the block's design file and its control bench.
`ifndef PTC_DEFINES_VH
`define PTC_DEFINES_VH

// Register byte offsets (one aligned word each)
`define PTC_OFS_EVEN_CTRL 6'h00
`define PTC_OFS_ODD_CTRL 6'h04
`define PTC_OFS_EVEN_CNT 6'h08
`define PTC_OFS_ODD_CNT 6'h0C
`define PTC_OFS_EVEN_PER 6'h10
`define PTC_OFS_ODD_PER 6'h14
`define PTC_OFS_STATUS 6'h18

// Control field positions
`define PTC_RUN 15
`define PTC_IDLE_STOP 13
`define PTC_XSEL_HI 9
`define PTC_XSEL_LO 8
`define PTC_GATE 6
`define PTC_PRE_HI 5
`define PTC_PRE_LO 4
`define PTC_JOIN 3
`define PTC_CSRC 1

// Implemented bit masks; everything else reads zero
`define PTC_EVEN_MASK 16'hA37A
`define PTC_ODD_MASK 16'hA372
`define PTC_CTRL_RST 16'h0000
`define PTC_CNT_RST 16'h0000
`define PTC_PER_RST 16'hFFFF

// Extended clock select codes
`define PTC_XSEL_SECONDARY_OSCILLATOR 2'h0
`define PTC_XSEL_PIN 2'h1
`define PTC_XSEL_LOW_POWER_RC_OSCILLATOR 2'h2
`define PTC_XSEL_GEN 2'h3

// Prescale codes and terminal counts (ratio minus one)
`define PTC_PRE_1 2'h0
`define PTC_PRE_8 2'h1
`define PTC_PRE_64 2'h2
`define PTC_PRE_256 2'h3
`define PTC_TC_1 8'h00
`define PTC_TC_8 8'h07
`define PTC_TC_64 8'h3F
`define PTC_TC_256 8'hFF

// AHB transfer and status bit positions
`define PTC_HTRANS_NSEQ 1
`define PTC_ST_EVEN 0
`define PTC_ST_ODD 1

`endif

// ### src/ptc_paired_timer.v
// Paired 16-bit timers that can join into one 32-bit timer, with an
// AHB-Lite register slave, clock source select, gating and prescale.
// Assumes every input is synchronous to clk and clk is the Fosc/2 rate.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.vh"

// Behaviour
// - Even run bit runs pair or even
// - Idle-stop bit halts timer during idle
// - Extended select picks external clock source
// - Clock-source zero uses internal Fosc/2
// - Gate enable works only with internal clock
// - Prescale 1, 8, 64 or 256
// - Control write while running clears prescaler
// - Join bit makes one 32-bit timer
// - Odd control ignored while joined
// - Odd run bit runs odd alone
// - Odd clock-source selects external edges
// - Unimplemented control bits read zero
// - Even low half, odd high half
// - Joined match flags the odd timer
// - Period split odd high, even low
module ptc_paired_timer (
	input wire clk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire idleMode,
	input wire secondaryOscillator,
	input wire lowPowerRcOscillator,
	input wire genericExternalTimerInput,
	input wire evenTimerClockPin,
	input wire oddTimerClockPin,
	input wire evenGateIn,
	input wire oddGateIn,
	output reg evenMatch,
	output reg oddMatch
);

	// Register state
	reg [15:0] evenCtrl_ff; // Even control word
	reg [15:0] oddCtrl_ff; // Odd control word
	reg [15:0] evenCnt_ff; // Low count half
	reg [15:0] oddCnt_ff; // High count half
	reg [15:0] evenPer_ff; // Low period half
	reg [15:0] oddPer_ff; // High period half
	reg [1:0] status_ff; // Sticky match flags

	// Bus data-phase state
	reg wrPend_ff; // Write data phase pending
	reg rdPend_ff; // Read data phase pending
	reg [5:0] addr_ff; // Latched word offset

	// External edge history, one per source
	reg [4:0] srcPrev_ff;
	wire [4:0] srcNow;
	wire [4:0] srcRise;

	// Per-timer effective controls and ticks
	wire joined;
	wire [15:0] effCtrl [0:1];
	wire [1:0] gateIn;
	wire [1:0] pinRise;
	wire [1:0] tick;
	wire [1:0] ctrlWrRun;

	// Bus decode
	wire addrPhase;
	wire wrEven;
	wire wrOdd;

	assign addrPhase = hsel & htrans[`PTC_HTRANS_NSEQ] & hready;
	assign wrEven = wrPend_ff & (addr_ff == `PTC_OFS_EVEN_CTRL);
	assign wrOdd = wrPend_ff & (addr_ff == `PTC_OFS_ODD_CTRL);

	// Join bit lives only in the even word
	assign joined = evenCtrl_ff[`PTC_JOIN];
	// Joined pair takes every setting from the even word
	assign effCtrl[0] = evenCtrl_ff;
	assign effCtrl[1] = joined ? evenCtrl_ff : oddCtrl_ff;

	// Edge detect on plain synchronous inputs
	assign srcNow = {genericExternalTimerInput, lowPowerRcOscillator, secondaryOscillator,
		oddTimerClockPin, evenTimerClockPin};
	assign srcRise = srcNow & ~srcPrev_ff;
	assign pinRise = srcRise[1:0];
	assign gateIn = {oddGateIn, evenGateIn};

	// Source edge history
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			srcPrev_ff <= 5'h00;
		end else begin
			srcPrev_ff <= srcNow;
		end
	end

	// A write to a running timer's control word counts as a restart
	assign ctrlWrRun[0] = wrEven & evenCtrl_ff[`PTC_RUN];
	assign ctrlWrRun[1] = wrOdd & oddCtrl_ff[`PTC_RUN] & ~joined;

	// Clock select, gate and prescale for each timer
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
			reg [7:0] pre_ff; // Prescale counter
			reg [7:0] nxt_pre;
			reg [7:0] preTc;
			reg rawTick;
			reg running;
			reg extEdge;

			// Source and enable selection
			always @* begin
				// Even timer's source drives the joined pair
				running = effCtrl[gi][`PTC_RUN];
				if (effCtrl[gi][`PTC_IDLE_STOP] && idleMode) begin
					running = 1'b0;
				end
				case (effCtrl[gi][`PTC_XSEL_HI:`PTC_XSEL_LO])
					`PTC_XSEL_GEN: extEdge = srcRise[4];
					`PTC_XSEL_LOW_POWER_RC_OSCILLATOR: extEdge = srcRise[3];
					`PTC_XSEL_PIN: extEdge = pinRise[gi];
					`PTC_XSEL_SECONDARY_OSCILLATOR: extEdge = srcRise[2];
					default: extEdge = 1'b0;
				endcase
				if (effCtrl[gi][`PTC_CSRC]) begin
					// Gate is ignored for external sources
					rawTick = extEdge;
				end else if (effCtrl[gi][`PTC_GATE]) begin
					// Accumulate internal clocks while gate is high
					rawTick = gateIn[gi];
				end else begin
					rawTick = 1'b1;
				end
				case (effCtrl[gi][`PTC_PRE_HI:`PTC_PRE_LO])
					`PTC_PRE_1: preTc = `PTC_TC_1;
					`PTC_PRE_8: preTc = `PTC_TC_8;
					`PTC_PRE_64: preTc = `PTC_TC_64;
					`PTC_PRE_256: preTc = `PTC_TC_256;
					default: preTc = `PTC_TC_1;
				endcase
				nxt_pre = pre_ff;
				if (ctrlWrRun[gi]) begin
					nxt_pre = 8'h00;
				end else if (running && rawTick) begin
					nxt_pre = (pre_ff >= preTc) ? 8'h00 : pre_ff + 8'h01;
				end
			end

			// Tick on the input edge that completes the ratio
			assign tick[gi] = running & rawTick & (pre_ff >= preTc) & ~ctrlWrRun[gi];

			// Prescale counter
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					pre_ff <= 8'h00;
				end else begin
					pre_ff <= nxt_pre;
				end
			end
		end
	endgenerate

	// Count, period and match
	reg [15:0] nxt_evenCnt;
	reg [15:0] nxt_oddCnt;
	reg nxt_evenMatch;
	reg nxt_oddMatch;

	// Software count writes win over counting in the same cycle
	always @* begin
		nxt_evenCnt = evenCnt_ff;
		nxt_oddCnt = oddCnt_ff;
		nxt_evenMatch = 1'b0;
		nxt_oddMatch = 1'b0;
		if (joined) begin
			// Even half is low word, odd half high word
			if (tick[0]) begin
				if ({oddCnt_ff, evenCnt_ff} == {oddPer_ff, evenPer_ff}) begin
					nxt_evenCnt = `PTC_CNT_RST;
					nxt_oddCnt = `PTC_CNT_RST;
					nxt_oddMatch = 1'b1;
				end else begin
					{nxt_oddCnt, nxt_evenCnt} = {oddCnt_ff, evenCnt_ff} + 32'h0000_0001;
				end
			end
		end else begin
			// Two independent halves
			if (tick[0]) begin
				if (evenCnt_ff == evenPer_ff) begin
					nxt_evenCnt = `PTC_CNT_RST;
					nxt_evenMatch = 1'b1;
				end else begin
					nxt_evenCnt = evenCnt_ff + 16'h0001;
				end
			end
			if (tick[1]) begin
				if (oddCnt_ff == oddPer_ff) begin
					nxt_oddCnt = `PTC_CNT_RST;
					nxt_oddMatch = 1'b1;
				end else begin
					nxt_oddCnt = oddCnt_ff + 16'h0001;
				end
			end
		end
		if (wrPend_ff && addr_ff == `PTC_OFS_EVEN_CNT) begin
			nxt_evenCnt = hwdata[15:0];
		end
		if (wrPend_ff && addr_ff == `PTC_OFS_ODD_CNT) begin
			nxt_oddCnt = hwdata[15:0];
		end
	end

	// Registers and match events
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			evenCtrl_ff <= `PTC_CTRL_RST;
			oddCtrl_ff <= `PTC_CTRL_RST;
			evenCnt_ff <= `PTC_CNT_RST;
			oddCnt_ff <= `PTC_CNT_RST;
			evenPer_ff <= `PTC_PER_RST;
			oddPer_ff <= `PTC_PER_RST;
			status_ff <= 2'h0;
			evenMatch <= 1'b0;
			oddMatch <= 1'b0;
		end else begin
			evenCnt_ff <= nxt_evenCnt;
			oddCnt_ff <= nxt_oddCnt;
			evenMatch <= nxt_evenMatch;
			oddMatch <= nxt_oddMatch;
			if (wrEven) begin
				evenCtrl_ff <= hwdata[15:0] & `PTC_EVEN_MASK;
			end
			if (wrOdd) begin
				oddCtrl_ff <= hwdata[15:0] & `PTC_ODD_MASK;
			end
			if (wrPend_ff && addr_ff == `PTC_OFS_EVEN_PER) begin
				evenPer_ff <= hwdata[15:0];
			end
			if (wrPend_ff && addr_ff == `PTC_OFS_ODD_PER) begin
				oddPer_ff <= hwdata[15:0];
			end
			// Write one to clear; a new match in the same cycle wins
			if (wrPend_ff && addr_ff == `PTC_OFS_STATUS) begin
				status_ff <= (status_ff & ~hwdata[1:0]) | {nxt_oddMatch, nxt_evenMatch};
			end else begin
				status_ff <= status_ff | {nxt_oddMatch, nxt_evenMatch};
			end
		end
	end

	// Read mux, sampled one cycle after the address phase so that a
	// write in the previous data phase is already visible
	reg [31:0] rdMux;
	always @* begin
		case (addr_ff)
			`PTC_OFS_EVEN_CTRL: rdMux = {16'h0000, evenCtrl_ff};
			`PTC_OFS_ODD_CTRL: rdMux = {16'h0000, oddCtrl_ff};
			`PTC_OFS_EVEN_CNT: rdMux = {16'h0000, evenCnt_ff};
			`PTC_OFS_ODD_CNT: rdMux = {16'h0000, oddCnt_ff};
			`PTC_OFS_EVEN_PER: rdMux = {16'h0000, evenPer_ff};
			`PTC_OFS_ODD_PER: rdMux = {16'h0000, oddPer_ff};
			`PTC_OFS_STATUS: rdMux = {30'h0000_0000, status_ff};
			default: rdMux = 32'h0000_0000; // Unmapped reads zero
		endcase
	end

	// AHB-Lite slave: writes take no wait, reads one wait state
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPend_ff <= 1'b0;
			rdPend_ff <= 1'b0;
			addr_ff <= 6'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0; // Always OKAY
			if (rdPend_ff) begin
				// Wait state over, present data
				hrdata <= rdMux;
				hreadyout <= 1'b1;
				rdPend_ff <= 1'b0;
				wrPend_ff <= 1'b0;
			end else if (addrPhase) begin
				addr_ff <= {haddr[5:2], 2'h0};
				wrPend_ff <= hwrite;
				rdPend_ff <= ~hwrite;
				hreadyout <= hwrite;
			end else begin
				wrPend_ff <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ### bench/ptc_paired_timer_monitor.sv
// Checker for the paired timer block: bus handshake and match pulses.
// Assumes the bench ties hready to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module ptc_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic evenMatch,
	input wire logic oddMatch
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Request taken at this edge
	wire accReq = hsel & htrans[1] & hready;
	hresp_okay_a: assert property (hresp == 1'h0) else $error("error response");
	write_no_wait_a: assert property (accReq && hwrite |=> hreadyout) else $error("write stalled");
	read_one_wait_a: assert property (accReq && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	wait_cause_a: assert property ($fell(hreadyout) |-> $past(accReq && !hwrite))
		else $error("stray wait state");
	rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	rdata_upper_a: assert property (hrdata[31:16] == 16'h0000) else $error("upper bits set");
	even_pulse_a: assert property (evenMatch |=> !evenMatch) else $error("even pulse long");
	odd_pulse_a: assert property (oddMatch |=> !oddMatch) else $error("odd pulse long");
endmodule
`default_nettype wire

// ### bench/test_paired_timer_control.sv
// Self-checking bench for the paired timer block over AHB-Lite.
// Assumes clk is the internal timer clock and sources are slow levels.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.vh"
module test_paired_timer_control;
	localparam logic [31:0] EC = `PTC_OFS_EVEN_CTRL, OC = `PTC_OFS_ODD_CTRL;
	localparam logic [31:0] ECN = `PTC_OFS_EVEN_CNT, OCN = `PTC_OFS_ODD_CNT;
	localparam logic [31:0] EP = `PTC_OFS_EVEN_PER, OP = `PTC_OFS_ODD_PER;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, idleMode = 0, gate = 0;
	logic [31:0] haddr = 0, hwdata = 0, v;
	logic [1:0] htrans = 0, sc = 0;
	logic [4:0] srcOn = 0; // Which source toggles
	wire [31:0] hrdata;
	wire hreadyout, hresp, evenMatch, oddMatch;
	int fails = 0, cmp_count = 0, eh = 0, oh = 0, e;
	always #2 clk = ~clk;
	// Slow source edges, one every four clocks
	always @(posedge clk) sc <= sc + 2'h1;
	// Tally match pulses
	always @(posedge clk) begin
		if (evenMatch === 1'h1) eh <= eh + 1;
		if (oddMatch === 1'h1) oh <= oh + 1;
	end
	ptc_paired_timer dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .idleMode(idleMode),
		.secondaryOscillator(srcOn[0] & sc[1]), .evenTimerClockPin(srcOn[1] & sc[1]),
		.lowPowerRcOscillator(srcOn[2] & sc[1]), .genericExternalTimerInput(srcOn[3] & sc[1]),
		.oddTimerClockPin(srcOn[4] & sc[1]), .evenGateIn(gate), .oddGateIn(gate),
		.evenMatch(evenMatch), .oddMatch(oddMatch));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function logic [31:0] inRange(input logic [31:0] x, input int lo, input int hi);
		return {31'h0, (x >= lo && x <= hi)};
	endfunction
	function logic [31:0] cw(input logic r, i, input logic [1:0] x, input logic g,
		input logic [1:0] p, input logic j, c);
		return {16'h0000, r, 1'h0, i, 3'h0, x, 1'h0, g, p, j, 1'h0, c, 1'h0};
	endfunction
	// One bus transfer; hold each phase until hready is seen high
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
		do @(posedge clk); while (hreadyout !== 1'h1);
		hsel <= 0; htrans <= 2'h0; hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		q = hrdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1, a, d, q);
	endtask
	task rd(input logic [31:0] a, output logic [31:0] q);
		xfer(0, a, 0, q);
	endtask
	// Clear count, run for n cycles, stop, read count
	task run(input logic [31:0] ca, input logic [31:0] c, input int n);
		wr(ca + 8, 0); wr(ca, c);
		repeat (n) @(posedge clk);
		wr(ca, 0); rd(ca + 8, v);
	endtask
	task s_reset;
		rd(EC, v); chk(v, 0);
		rd(OC, v); chk(v, 0);
		wr(EC, 32'hFFFF); rd(EC, v); chk(v, 32'hA37A);
		wr(OC, 32'hFFFF); rd(OC, v); chk(v, 32'hA372);
		wr(EC, 0); wr(OC, 0);
		rd(32'h001C, v); chk(v, 0);
	endtask
	task s_pre;
		for (int p = 0; p < 4; p++) begin
			run(EC, cw(1, 0, 0, 0, p, 0, 0), 1024);
			e = 1024 >> (p == 0 ? 0 : p == 1 ? 3 : p == 2 ? 6 : 8);
			chk(inRange(v, e - 2, e + 6), 1);
		end
	endtask
	task s_restart; // Rewrite while running restarts the 1:256 prescaler
		wr(ECN, 0); wr(EC, cw(1, 0, 0, 0, 3, 0, 0));
		repeat (200) @(posedge clk);
		wr(EC, cw(1, 0, 0, 0, 3, 0, 0));
		repeat (200) @(posedge clk);
		wr(EC, 0); rd(ECN, v); chk(v, 0);
	endtask
	task s_src;
		for (int x = 0; x < 4; x++) begin
			// Only the routed source toggles before its select is used
			srcOn <= 5'h01 << x;
			run(EC, cw(1, 0, x, 1, 0, 0, 1), 256);
			chk(inRange(v, 62, 66), 1);
		end
		srcOn <= 5'h10;
		run(OC, cw(1, 0, 1, 0, 0, 0, 1), 256); chk(inRange(v, 62, 66), 1);
		srcOn <= 0;
	endtask
	task s_gate_idle;
		run(EC, cw(1, 0, 0, 1, 0, 0, 0), 100); chk(v, 0);
		gate <= 1;
		run(EC, cw(1, 0, 0, 1, 0, 0, 0), 100); chk(inRange(v, 99, 106), 1);
		gate <= 0; idleMode <= 1;
		run(EC, cw(1, 1, 0, 0, 0, 0, 0), 100); chk(v, 0);
		run(EC, cw(1, 0, 0, 0, 0, 0, 0), 100); chk(inRange(v, 99, 106), 1);
		idleMode <= 0;
	endtask
	// Joined pair from FFFE for 20 cycles; odd control stopped and odd
	task jrun;
		wr(ECN, 32'hFFFE); wr(OCN, 0); eh = 0; oh = 0;
		wr(EC, cw(1, 0, 0, 0, 0, 1, 0));
		repeat (20) @(posedge clk);
		wr(EC, cw(0, 0, 0, 0, 0, 1, 0));
	endtask
	task s_join;
		wr(EC, cw(0, 0, 0, 0, 0, 1, 0)); wr(OC, cw(0, 1, 3, 1, 3, 0, 1));
		jrun; rd(OCN, v); chk(v, 1);
		rd(ECN, v); chk(inRange(v, 12, 22), 1);
		wr(EP, 2); wr(OP, 1);
		jrun; rd(OCN, v); chk(v, 0);
		chk(oh, 1);
		chk(eh, 0);
		wr(EC, 0); wr(OC, 0);
	endtask
	task s_odd;
		wr(OP, 3); wr(ECN, 0); eh = 0; oh = 0;
		run(OC, cw(1, 0, 0, 0, 0, 0, 0), 16);
		chk(inRange(oh, 3, 5), 1);
		chk(eh, 0);
		rd(ECN, v); chk(v, 0);
		// Even half alone with period 3 matches every fourth tick
		wr(EP, 3);
		eh = 0;
		oh = 0;
		run(EC, cw(1, 0, 0, 0, 0, 0, 0), 16);
		chk(inRange(eh, 3, 5), 1);
		chk(oh, 0);
		// Sticky flags: both halves have matched by now, write one clears
		rd(32'h0018, v);
		chk(v, 3);
		wr(32'h0018, 3);
		rd(32'h0018, v);
		chk(v, 0);
	endtask
	// Reset in mid-run returns every control bit to zero
	task s_rerst;
		wr(EC, cw(1, 0, 0, 0, 1, 1, 0));
		wr(OC, cw(1, 1, 0, 0, 2, 0, 1));
		repeat (8) @(posedge clk);
		rst <= 1;
		repeat (5) @(posedge clk);
		rst <= 0;
		rd(EC, v);
		chk(v, 0);
		rd(OC, v);
		chk(v, 0);
		rd(ECN, v);
		chk(v, 0);
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, well past the expected 26 us
	initial begin
		#200000;
		fails++;
		conclude;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		s_reset; s_pre; s_restart; s_src; s_gate_idle; s_join; s_odd;
		s_rerst;
		conclude;
	end
endmodule
bind ptc_paired_timer ptc_monitor mon (.clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.evenMatch(evenMatch), .oddMatch(oddMatch));
`default_nettype wire
